/* rtl/llm_defines.vh */
`ifndef LLM_DEFINES_VH
`define LLM_DEFINES_VH
// Thermal defaults, degrees C, 8-bit signed-free code
`define OT_TRIP_DEFAULT     8'h7D
`define OT_HYST             8'h19
// Thermal response encodings
`define OT_RESP_IGNORE      2'h0
`define OT_RESP_RESTART     2'h1
`define OT_RESP_LATCH       2'h2
`define OT_RESP_DEFAULT     2'h1
// Light-load entry and exit counts
`define ZC_ENTRY_COUNT      4'h8
`define BELOW_EXIT_COUNT    2'h3
// 95 percent of reference: ref*243/256
`define UV95_NUM            8'hF3
// Power states
`define PS_0                3'h0
`define PS_1                3'h1
`define PS_2                3'h2
`define PS_4                3'h4
// Settling of error amplifier sample after ramp end, cycles
`define CAL_DELAY_NS        2000
`define CLK_PERIOD_NS       20
`define CAL_DELAY_CYC       ((`CAL_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* rtl/vsense_compare.v */
`timescale 1ns/1ps
`include "llm_defines.vh"
module vsense_compare #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] sense_code,
    input  wire [W-1:0] ov_warn_limit,
    input  wire [W-1:0] uv_fault_limit,
    input  wire [W-1:0] uv_warn_limit,
    output reg  [W-1:0] vout_q,
    output reg          ov_warn_q,
    output reg          uv_fault_q,
    output reg          uv_warn_q
);
    // Sense code is in 1/256 V units; reported unchanged
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vout_q     <= {W{1'b0}};
            ov_warn_q  <= 1'b0;
            uv_fault_q <= 1'b0;
            uv_warn_q  <= 1'b0;
        end else begin
            vout_q     <= sense_code;
            ov_warn_q  <= sense_code > ov_warn_limit;
            uv_fault_q <= sense_code < uv_fault_limit;
            uv_warn_q  <= sense_code < uv_warn_limit;
        end
    end
endmodule // vsense_compare

/* rtl/light_load_ctrl.v */
`timescale 1ns/1ps
`include "llm_defines.vh"
// Summary of operation
// - Default thermal trip level is 125 degrees.
// - Default response: over-trip drops conversion enable, both drives off.
// - Auto restart once temperature falls more than 25 degrees below trip.
// - Thermal response: ignore, inhibit with restart, or latched shutdown.
// - Trip level and response are overridable by configuration inputs.
// - Forced continuous bit 0 permits autonomous light-load operation.
// - Power-state mode: autonomous with bit clear, commanded with bit set.
// - With bit set, PS2-4 allow light load; PS0, PS1, raise disable.
// - After ramp end, error amp level sampled, stored, reproduced.
// - Enter light load after 8 consecutive cycles with zero crossing.
// - Light load: fixed pulse, low side to zero, both off to ref.
// - Leave light load when output falls to 95 percent of reference.
// - Leave light load after 3 zero crossings with sense at or below ref.
// - Pulse delayed until current decays when sense reaches ref early.
// - Light load blocked in transitions until ramp done and resampled.
// - Output voltage reported from sense input at 1/256 V.
// - Warnings and fault from digitised sense against thresholds.
module light_load_ctrl #(
    parameter VW          = 16,
    parameter CW          = 10,
    parameter ON_TIME_CYC = 8
) (
    input  wire          CLOCK,
    input  wire          RSTN,
    input  wire          ENABLE,
    input  wire [7:0]    DIE_TEMP,
    input  wire          OT_LIMIT_OVERRIDE,
    input  wire [7:0]    OT_LIMIT,
    input  wire          OT_RESPONSE_OVERRIDE,
    input  wire [1:0]    OT_RESPONSE,
    input  wire          OT_LATCH_CLEAR,
    input  wire          FORCED_CONTINUOUS,
    input  wire          POWER_STATE_MODE,
    input  wire          POWER_STATE_CMD,
    input  wire [2:0]    POWER_STATE_CMD_VALUE,
    input  wire          VOLTAGE_RAISE_CMD,
    input  wire          POWER_STATE_OVERRIDE_ENABLE,
    input  wire [2:0]    POWER_STATE_OVERRIDE_VALUE,
    input  wire          REF_RAMPING,
    input  wire [CW-1:0] ERROR_AMP_CODE,
    input  wire          CYCLE_START,
    input  wire          ZERO_CROSS,
    input  wire          PWM_HIGH,
    input  wire          PWM_LOW,
    input  wire [VW-1:0] SENSE_CODE,
    input  wire [VW-1:0] REF_CODE,
    input  wire [VW-1:0] OV_WARN_LIMIT,
    input  wire [VW-1:0] UV_FAULT_LIMIT,
    input  wire [VW-1:0] UV_WARN_LIMIT,
    output reg           CONVERSION_ENABLE,
    output reg           OT_FAULT,
    output reg           HIGH_SIDE_DRIVE,
    output reg           LOW_SIDE_DRIVE,
    output reg           ADAPTIVE_ON_TIME_MODE,
    output reg  [CW-1:0] CAL_LEVEL,
    output wire [VW-1:0] VOUT_READ,
    output wire          OV_WARN,
    output wire          UV_FAULT,
    output wire          UV_WARN
);
    ////////////////////////////////////////////////////////////////////////
    // Thermal fault
    wire [7:0] trip = OT_LIMIT_OVERRIDE ? OT_LIMIT : `OT_TRIP_DEFAULT;
    wire [1:0] resp = OT_RESPONSE_OVERRIDE ? OT_RESPONSE
                                           : `OT_RESP_DEFAULT;
    wire [7:0] restart_lvl = (trip > `OT_HYST) ? (trip - `OT_HYST) : 8'h00;
    reg        hot_q;
    reg        ot_latch_q;
    reg        ot_inhibit;

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            hot_q      <= 1'b0;
            ot_latch_q <= 1'b0;
        end else begin
            if (DIE_TEMP > trip)
                hot_q <= 1'b1;
            else if (DIE_TEMP < restart_lvl)
                hot_q <= 1'b0;
            // Set wins over a clear in the same cycle
            if (resp == `OT_RESP_LATCH && DIE_TEMP > trip)
                ot_latch_q <= 1'b1;
            else if (OT_LATCH_CLEAR || !ENABLE)
                ot_latch_q <= 1'b0;
        end
    end

    always @* begin
        case (resp)
            `OT_RESP_IGNORE:  ot_inhibit = ot_latch_q;
            `OT_RESP_RESTART: ot_inhibit = hot_q | ot_latch_q;
            default:          ot_inhibit = ot_latch_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Light-load permission
    reg ps_allow_q;

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ps_allow_q <= 1'b0;
        end else if (VOLTAGE_RAISE_CMD) begin
            ps_allow_q <= 1'b0;
        end else if (POWER_STATE_CMD) begin
            ps_allow_q <= (POWER_STATE_CMD_VALUE >= `PS_2) &&
                          (POWER_STATE_CMD_VALUE <= `PS_4);
        end
    end

    reg permit;
    always @* begin
        if (POWER_STATE_MODE && POWER_STATE_OVERRIDE_ENABLE)
            // Override value stands in place of commanded state
            permit = FORCED_CONTINUOUS ?
                     (POWER_STATE_OVERRIDE_VALUE >= `PS_2 &&
                      POWER_STATE_OVERRIDE_VALUE <= `PS_4) : 1'b1;
        else if (POWER_STATE_MODE)
            permit = FORCED_CONTINUOUS ? ps_allow_q : 1'b1;
        else
            permit = !FORCED_CONTINUOUS;
    end

    ////////////////////////////////////////////////////////////////////////
    // Error amplifier calibration after each ramp
    localparam CALW = 8;
    localparam integer    CAL_CYC_N = `CAL_DELAY_CYC;
    localparam [CALW-1:0] CAL_CYC   = CAL_CYC_N[CALW-1:0];
    reg [CALW-1:0] cal_cnt_q;
    reg            cal_valid_q;

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            cal_cnt_q   <= {CALW{1'b0}};
            cal_valid_q <= 1'b0;
            CAL_LEVEL   <= {CW{1'b0}};
        end else if (REF_RAMPING || !ENABLE) begin
            cal_cnt_q   <= {CALW{1'b0}};
            cal_valid_q <= 1'b0;
        end else if (!cal_valid_q) begin
            if (cal_cnt_q == CAL_CYC - 8'h01) begin
                CAL_LEVEL   <= ERROR_AMP_CODE;
                cal_valid_q <= 1'b1;
            end else begin
                cal_cnt_q <= cal_cnt_q + 8'h01;
            end
        end
    end

    wire ll_ok = permit && cal_valid_q && !REF_RAMPING && CONVERSION_ENABLE;

    ////////////////////////////////////////////////////////////////////////
    // Mode control
    localparam [3:0] S_PWM  = 4'h1;
    localparam [3:0] S_HIGH = 4'h2;
    localparam [3:0] S_LOW  = 4'h4;
    localparam [3:0] S_IDLE = 4'h8;

    reg [3:0] state_q;
    reg [3:0] zc_cnt_q;
    reg [1:0] below_cnt_q;
    reg [7:0] on_cnt_q;
    wire      zc_pend;
    wire      at_ref   = SENSE_CODE <= REF_CODE;
    wire [VW+7:0] ref95 = REF_CODE * `UV95_NUM;
    wire      below95  = {SENSE_CODE, 8'h00} <= ref95;
    reg       zc_seen_q;
    reg       zc_now_q;

    assign zc_pend = zc_seen_q | ZERO_CROSS;

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_q     <= S_PWM;
            zc_cnt_q    <= 4'h0;
            below_cnt_q <= 2'h0;
            on_cnt_q    <= 8'h00;
            zc_seen_q   <= 1'b0;
            zc_now_q    <= 1'b0;
        end else begin
            zc_now_q <= 1'b0;
            case (state_q)
                S_PWM: begin
                    below_cnt_q <= 2'h0;
                    if (ZERO_CROSS)
                        zc_seen_q <= 1'b1;
                    if (!ll_ok) begin
                        // Crossings seen while refused must not count later
                        zc_cnt_q  <= 4'h0;
                        zc_seen_q <= 1'b0;
                    end else if (CYCLE_START) begin
                        zc_seen_q <= ZERO_CROSS;
                        if (!zc_seen_q) begin
                            zc_cnt_q <= 4'h0;
                        end else if (zc_cnt_q == `ZC_ENTRY_COUNT - 4'h1) begin
                            zc_cnt_q <= 4'h0;
                            state_q  <= S_IDLE;
                        end else begin
                            zc_cnt_q <= zc_cnt_q + 4'h1;
                        end
                    end
                end
                S_HIGH: begin
                    // Constant width pulse
                    if (on_cnt_q == ON_TIME_CYC[7:0] - 8'h01) begin
                        on_cnt_q <= 8'h00;
                        state_q  <= S_LOW;
                    end else begin
                        on_cnt_q <= on_cnt_q + 8'h01;
                    end
                end
                S_LOW: begin
                    if (ZERO_CROSS) begin
                        state_q  <= S_IDLE;
                        zc_now_q <= 1'b1;
                    end
                end
                S_IDLE: begin
                    if (zc_now_q) begin
                        if (at_ref) begin
                            if (below_cnt_q == `BELOW_EXIT_COUNT - 2'h1)
                                state_q <= S_PWM;
                            below_cnt_q <= below_cnt_q + 2'h1;
                        end else begin
                            below_cnt_q <= 2'h0;
                        end
                    end
                    // Idle means current already at zero
                    if (at_ref && !ZERO_CROSS && !zc_now_q)
                        state_q <= S_HIGH;
                end
                default: state_q <= S_PWM;
            endcase
            if (state_q != S_PWM && (below95 || !ll_ok)) begin
                state_q   <= S_PWM;
                zc_seen_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive outputs
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            CONVERSION_ENABLE     <= 1'b0;
            OT_FAULT              <= 1'b0;
            HIGH_SIDE_DRIVE       <= 1'b0;
            LOW_SIDE_DRIVE        <= 1'b0;
            ADAPTIVE_ON_TIME_MODE <= 1'b0;
        end else begin
            CONVERSION_ENABLE     <= ENABLE && !ot_inhibit;
            OT_FAULT              <= hot_q | ot_latch_q;
            ADAPTIVE_ON_TIME_MODE <= state_q != S_PWM;
            if (!(ENABLE && !ot_inhibit)) begin
                HIGH_SIDE_DRIVE <= 1'b0;
                LOW_SIDE_DRIVE  <= 1'b0;
            end else if (state_q == S_PWM) begin
                HIGH_SIDE_DRIVE <= PWM_HIGH;
                LOW_SIDE_DRIVE  <= PWM_LOW && !PWM_HIGH;
            end else begin
                HIGH_SIDE_DRIVE <= state_q == S_HIGH;
                LOW_SIDE_DRIVE  <= state_q == S_LOW;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    vsense_compare #(
        .W (VW)
    ) u_cmp (
        .clk            (CLOCK),
        .rst_n          (RSTN),
        .sense_code     (SENSE_CODE),
        .ov_warn_limit  (OV_WARN_LIMIT),
        .uv_fault_limit (UV_FAULT_LIMIT),
        .uv_warn_limit  (UV_WARN_LIMIT),
        .vout_q         (VOUT_READ),
        .ov_warn_q      (OV_WARN),
        .uv_fault_q     (UV_FAULT),
        .uv_warn_q      (UV_WARN)
    );
endmodule // light_load_ctrl

/* tb/switch_stage_model.sv */
`timescale 1ns/1ps
// Power stage stand-in: cycle start every 8 clocks, crossing mid-period
module switch_stage_model (
    input  wire clk,
    input  wire rst_n,
    input  wire zc_on,
    output reg  cycle_start,
    output reg  zero_cross
);
    reg [2:0] phase_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q     <= 3'h0;
            cycle_start <= 1'b0;
            zero_cross  <= 1'b0;
        end else begin
            phase_q     <= phase_q + 3'h1;
            cycle_start <= phase_q == 3'h7;
            zero_cross  <= zc_on && phase_q == 3'h3;
        end
    end
endmodule // switch_stage_model

/* tb/light_load_ctrl_checker.sv */
`timescale 1ns/1ps
module light_load_ctrl_checker #(
    parameter VW = 16,
    parameter CW = 10
) (
    input wire          CLOCK,
    input wire          RSTN,
    input wire          ENABLE,
    input wire [7:0]    DIE_TEMP,
    input wire          OT_LIMIT_OVERRIDE,
    input wire          OT_RESPONSE_OVERRIDE,
    input wire [1:0]    OT_RESPONSE,
    input wire          REF_RAMPING,
    input wire [CW-1:0] ERROR_AMP_CODE,
    input wire [VW-1:0] SENSE_CODE,
    input wire [VW-1:0] REF_CODE,
    input wire [VW-1:0] OV_WARN_LIMIT,
    input wire [VW-1:0] UV_FAULT_LIMIT,
    input wire          CONVERSION_ENABLE,
    input wire          HIGH_SIDE_DRIVE,
    input wire          LOW_SIDE_DRIVE,
    input wire          ADAPTIVE_ON_TIME_MODE,
    input wire [CW-1:0] CAL_LEVEL,
    input wire [VW-1:0] VOUT_READ,
    input wire          OV_WARN,
    input wire          UV_FAULT
);
    wire [VW+7:0] s256   = {SENSE_CODE, 8'h00};
    wire [VW+7:0] r243   = REF_CODE * 8'hF3;
    wire          low95  = s256 <= r243;
    wire          ov_hit = SENSE_CODE > OV_WARN_LIMIT;
    wire          uv_hit = SENSE_CODE < UV_FAULT_LIMIT;
    wire          dflt   = ENABLE && !OT_LIMIT_OVERRIDE && !OT_RESPONSE_OVERRIDE;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////
    property p_ot_trip;
        (dflt && DIE_TEMP > 8'h7D)[*4] |-> !CONVERSION_ENABLE;
    endproperty
    a_ot_trip: assert property (p_ot_trip) else $error("no trip");
    property p_drv_off;
        !CONVERSION_ENABLE[*2] |-> !HIGH_SIDE_DRIVE && !LOW_SIDE_DRIVE;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("drive on");
    property p_hyst;
        $fell(CONVERSION_ENABLE) && dflt && DIE_TEMP >= 8'h64
            |=> !CONVERSION_ENABLE;
    endproperty
    a_hyst: assert property (p_hyst) else $error("early restart");
    property p_ignore;
        (ENABLE && OT_RESPONSE_OVERRIDE && OT_RESPONSE == 2'h0)[*4]
            |-> CONVERSION_ENABLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("not ignored");
    property p_sense;
        1 |=> VOUT_READ == $past(SENSE_CODE) && OV_WARN == $past(ov_hit)
            && UV_FAULT == $past(uv_hit);
    endproperty
    a_sense: assert property (p_sense) else $error("sense bad");
    property p_cal;
        $fell(REF_RAMPING) |-> ##[99:102] CAL_LEVEL == ERROR_AMP_CODE;
    endproperty
    a_cal: assert property (p_cal) else $error("no sample");
    property p_ramp;
        REF_RAMPING[*3] |-> !ADAPTIVE_ON_TIME_MODE;
    endproperty
    a_ramp: assert property (p_ramp) else $error("mode in ramp");
    property p_uv95;
        low95[*4] |-> !ADAPTIVE_ON_TIME_MODE;
    endproperty
    a_uv95: assert property (p_uv95) else $error("no exit");
endmodule // light_load_ctrl_checker
bind light_load_ctrl light_load_ctrl_checker #(.VW(VW), .CW(CW))
    light_load_ctrl_checker_i (.*);

/* tb/light_load_ctrl_tb_top.sv */
`timescale 1ns/1ps
module light_load_ctrl_tb_top;
    reg        CLOCK = 1'b0, RSTN = 1'b0, ENABLE = 1'b1, zc_on = 1'b0;
    reg        OT_LIMIT_OVERRIDE = 1'b0, OT_RESPONSE_OVERRIDE = 1'b0;
    reg        OT_LATCH_CLEAR = 1'b0, FORCED_CONTINUOUS = 1'b0;
    reg        POWER_STATE_MODE = 1'b0, POWER_STATE_CMD = 1'b0;
    reg        VOLTAGE_RAISE_CMD = 1'b0, REF_RAMPING = 1'b1;
    reg        PWM_HIGH = 1'b0, PWM_LOW = 1'b0;
    reg        POWER_STATE_OVERRIDE_ENABLE = 1'b0;
    reg [7:0]  DIE_TEMP = 8'h32, OT_LIMIT = 8'h50;
    reg [1:0]  OT_RESPONSE = 2'h1;
    reg [2:0]  POWER_STATE_CMD_VALUE = 3'h0, POWER_STATE_OVERRIDE_VALUE = 3'h0;
    reg [9:0]  ERROR_AMP_CODE = 10'h0AA;
    reg [15:0] SENSE_CODE = 16'h0100, REF_CODE = 16'h0000;
    reg [15:0] OV_WARN_LIMIT = 16'h0110, UV_FAULT_LIMIT = 16'h00E0;
    reg [15:0] UV_WARN_LIMIT = 16'h00F0;
    wire       CYCLE_START, ZERO_CROSS, CONVERSION_ENABLE, OT_FAULT;
    wire       HIGH_SIDE_DRIVE, LOW_SIDE_DRIVE, ADAPTIVE_ON_TIME_MODE;
    wire       OV_WARN, UV_FAULT, UV_WARN;
    wire [9:0] CAL_LEVEL;
    wire [15:0] VOUT_READ;
    integer    miscompares = 0;
    integer    n_checks = 0;
    integer    v;
    light_load_ctrl light_load_ctrl_i (.*);
    switch_stage_model switch_stage_model_i (.clk(CLOCK), .rst_n(RSTN),
        .zc_on(zc_on), .cycle_start(CYCLE_START), .zero_cross(ZERO_CROSS));
    always #10 CLOCK = ~CLOCK;
    ////////////////////////////////////////////////////////////////////////
    task step(input integer n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    // Counts cycle starts, leaves just after one
    task cycles(input integer n);
        repeat (n) begin
            @(posedge CLOCK);
            while (!CYCLE_START) @(posedge CLOCK);
        end
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task temp_case(input [7:0] t, input ce);
        DIE_TEMP = t;
        step(4);
        chk(CONVERSION_ENABLE, ce);
    endtask
    task cmp_case(input [15:0] s, input [2:0] e);
        SENSE_CODE = s;
        step(2);
        chk(VOUT_READ, s);
        chk({OV_WARN, UV_FAULT, UV_WARN}, e);
    endtask
    task ps_cmd(input [2:0] p);
        POWER_STATE_CMD_VALUE = p;
        POWER_STATE_CMD = 1'b1;
        step(1);
        POWER_STATE_CMD = 1'b0;
    endtask
    task ll_case(input e);
        cycles(9);
        step(2);
        chk(ADAPTIVE_ON_TIME_MODE, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(3);
        RSTN = 1'b1;
        REF_CODE = 16'h0100;
        ERROR_AMP_CODE = 10'h155;
        cmp_case(16'h0110, 3'h0);
        cmp_case(16'h0111, 3'h4);
        cmp_case(16'h00F0, 3'h0);
        cmp_case(16'h00E0, 3'h1);
        cmp_case(16'h00DF, 3'h3);
        SENSE_CODE = 16'h0101;
        temp_case(8'h7D, 1'b1);
        temp_case(8'h7E, 1'b0);
        chk({HIGH_SIDE_DRIVE, LOW_SIDE_DRIVE}, 2'h0);
        chk(OT_FAULT, 1'b1);
        temp_case(8'h64, 1'b0);
        temp_case(8'h63, 1'b1);
        OT_LIMIT_OVERRIDE = 1'b1;
        temp_case(8'h51, 1'b0);
        temp_case(8'h37, 1'b0);
        temp_case(8'h36, 1'b1);
        OT_LIMIT_OVERRIDE = 1'b0;
        OT_RESPONSE_OVERRIDE = 1'b1;
        for (v = 0; v < 3; v = v + 1) begin
            OT_RESPONSE = v[1:0];
            temp_case(8'h96, v == 0);
            temp_case(8'h1E, v != 2);
        end
        OT_LATCH_CLEAR = 1'b1;
        temp_case(8'h1E, 1'b1);
        OT_LATCH_CLEAR = 1'b0;
        zc_on = 1'b1;
        ll_case(1'b0);
        zc_on = 1'b0;
        REF_RAMPING = 1'b0;
        step(105);
        chk(CAL_LEVEL, 10'h155);
        cycles(1);
        zc_on = 1'b1;
        cycles(7);
        zc_on = 1'b0;
        cycles(1);
        zc_on = 1'b1;
        cycles(7);
        step(2);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b0);
        cycles(1);
        step(2);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b1);
        SENSE_CODE = 16'h00F4;
        step(3);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b1);
        SENSE_CODE = 16'h00F3;
        step(3);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b0);
        SENSE_CODE = 16'h0101;
        cycles(1);
        ll_case(1'b1);
        SENSE_CODE = 16'h00FF;
        cycles(2);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b1);
        chk({HIGH_SIDE_DRIVE, LOW_SIDE_DRIVE}, 2'h2);
        // Two more pulse rounds of two switching cycles each
        cycles(4);
        step(2);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b0);
        SENSE_CODE = 16'h0101;
        FORCED_CONTINUOUS = 1'b1;
        POWER_STATE_MODE = 1'b1;
        ll_case(1'b0);
        for (v = 0; v < 5; v = v + 1) begin
            ps_cmd(v[2:0]);
            ll_case(v >= 2);
        end
        VOLTAGE_RAISE_CMD = 1'b1;
        step(1);
        VOLTAGE_RAISE_CMD = 1'b0;
        step(3);
        chk(ADAPTIVE_ON_TIME_MODE, 1'b0);
        POWER_STATE_OVERRIDE_ENABLE = 1'b1;
        ps_cmd(3'h2);
        ll_case(1'b0);
        report_and_stop;
    end
    // Whole run is near 1020 clocks
    initial begin
        #200000;
        miscompares = miscompares + 1;
        report_and_stop;
    end
endmodule // light_load_ctrl_tb_top
